// ==== hw/flash_self_program.sv ====
/*
 Self-programming controller for the program Flash, with an APB register port.
 Assumes the CPU core presents each store_program_memory_op as a one-cycle
 pulse with its target address and the address it executes from, and that
 lock and size fuses are static after reset.
*/
// Implementation choices: register access over APB and the register offsets.
//
// What this block does
// - A programming operation starts only when the op executes from the loader section.
// - An op from the loader section may target any page, loader section included.
// - The section boundary follows the loader-size fuses, not a fixed address.
// - Application pages obey lock set 0, loader pages obey lock set 1, independently.
// - Halt or keep fetching depends only on the fixed region of the target page.
// - During work on a fetch-during-write page, fetches from the halt region continue.
// - During work on a halt-during-write page, the CPU is halted for the whole operation.
// - The loader section always lies inside the halt-during-write region.
// - The busy flag reads one for as long as the fetch-during-write region is blocked.
// - Lock set 0 in its second mode refuses writes to the application section.
`timescale 1ns/100ps
module flash_self_program
	import flash_sp_pkg::*;
#(
	parameter int PROG_CYC = flash_sp_pkg::PROG_CYCLES
) (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [7:0]                 paddr,
	input  wire logic [31:0]                pwdata,
	output logic [31:0]                     prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic                       store_program_memory_op,
	input  wire flash_sp_pkg::spm_req_type  spm_req,
	input  wire logic [1:0]                 loader_size_fuses,
	input  wire logic [1:0]                 app_lock_bits,
	input  wire logic [1:0]                 loader_lock_bits,
	output logic                            cpu_halt,
	output logic                            rw_region_block,
	output logic                            flash_erase,
	output logic                            flash_write,
	output logic [flash_sp_pkg::PAGE_W-1:0] flash_page
);
	import flash_sp_pkg::*;

	// ------------------------------------------------------------
	// Address decoding helpers
	// ------------------------------------------------------------
	function automatic logic [PAGE_W-1:0] page_of(input logic [WADDR_W-1:0] a);
		return a[WADDR_W-1:PAGE_WORDS_W];
	endfunction

	// Loader sizes of 512, 1024, 2048 or 4096 words; never below the halt region
	function automatic logic [PAGE_W-1:0] loader_first(input logic [1:0] fz);
		logic [PAGE_W-1:0] p;
		p = 10'h3f8;
		case (fz)
			2'h3:    p = 10'h3fc;
			2'h2:    p = 10'h3f8;
			2'h1:    p = 10'h3f0;
			default: p = 10'h3e0;
		endcase
		if (p < HALT_REGION_FIRST_PAGE) p = HALT_REGION_FIRST_PAGE;
		return p;
	endfunction

	function automatic logic write_locked(input logic [1:0] lk);
		return (lk == LOCK_MODE2) || (lk == LOCK_MODE3);
	endfunction

	typedef enum logic {S_IDLE, S_RUN} state_type;

	state_type         state_r, state_nxt;
	logic              enable_r, enable_nxt;
	logic              busy_r, busy_nxt;
	logic              halt_r, halt_nxt;
	logic              refused_r, refused_nxt;
	logic              ignored_r, ignored_nxt;
	logic              erase_r, erase_nxt;
	logic              write_r, write_nxt;
	logic [PAGE_W-1:0] page_r, page_nxt;
	logic              start_pulse;
	logic              op_done;
	logic [PAGE_W-1:0] tgt_page;
	logic [PAGE_W-1:0] pc_page;
	logic [PAGE_W-1:0] boundary;
	logic              from_loader;
	logic              tgt_in_loader;
	logic              tgt_halt_region;
	logic              locked;

	// Fuses are static, so the boundary is plain combinational decode
	assign boundary        = loader_first(loader_size_fuses);
	assign tgt_page        = page_of(spm_req.target);
	assign pc_page         = page_of(spm_req.pc);
	assign from_loader     = (pc_page >= boundary);
	assign tgt_in_loader   = (tgt_page >= boundary);
	assign tgt_halt_region = (tgt_page >= HALT_REGION_FIRST_PAGE);
	assign locked = tgt_in_loader ? write_locked(loader_lock_bits) : write_locked(app_lock_bits);

	// ------------------------------------------------------------
	// APB slave: answers on the second access cycle
	// ------------------------------------------------------------
	logic        ready_r, ready_nxt;
	logic        err_r, err_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic        acc;
	logic        wr_ctrl;
	logic        mapped;
	assign acc     = psel && penable && ready_r;
	assign wr_ctrl = acc && pwrite && (paddr == OFS_CTRL);
	assign mapped  = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) || (paddr == OFS_CONFIG);
	always_comb begin
		ready_nxt = 1'b0;
		err_nxt   = 1'b0;
		rdata_nxt = 32'h0000_0000;
		if (psel && penable && !ready_r) begin
			ready_nxt = 1'b1;
			err_nxt   = !mapped || (pwrite && paddr != OFS_CTRL);
			if (!pwrite) begin
				case (paddr)
					OFS_CTRL:   rdata_nxt[CTRL_ENABLE_BIT] = enable_r;
					OFS_STATUS: rdata_nxt = {27'h0, ignored_r, refused_r, halt_r,
							state_r == S_RUN, busy_r};
					OFS_CONFIG: rdata_nxt = {26'h0, loader_lock_bits, app_lock_bits,
							loader_size_fuses};
					default:    rdata_nxt = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_r <= 1'b0;
			err_r   <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end else begin
			ready_r <= ready_nxt;
			err_r   <= err_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ------------------------------------------------------------
	// Operation sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_nxt   = state_r;
		enable_nxt  = enable_r;
		busy_nxt    = busy_r;
		halt_nxt    = halt_r;
		refused_nxt = refused_r;
		ignored_nxt = ignored_r;
		erase_nxt   = 1'b0;
		write_nxt   = 1'b0;
		page_nxt    = page_r;
		start_pulse = 1'b0;
		if (wr_ctrl) begin
			enable_nxt = pwdata[CTRL_ENABLE_BIT];
			// Clearing is refused mid-operation so the block cannot lift early
			if (pwdata[CTRL_RWCLEAR_BIT] && state_r == S_IDLE) busy_nxt = 1'b0;
			if (pwdata[ST_REFUSED_BIT + 8]) refused_nxt = 1'b0;
			if (pwdata[ST_IGNORED_BIT + 8]) ignored_nxt = 1'b0;
		end
		case (state_r)
			S_IDLE: begin
				if (store_program_memory_op && enable_r) begin
					if (!from_loader) begin
						ignored_nxt = 1'b1;
					end else if (spm_req.kind == OP_WRITE && locked) begin
						refused_nxt = 1'b1;
					end else begin
						// Any page is reachable, loader pages too
						state_nxt   = S_RUN;
						start_pulse = 1'b1;
						page_nxt    = tgt_page;
						erase_nxt   = (spm_req.kind == OP_ERASE);
						write_nxt   = (spm_req.kind == OP_WRITE);
						halt_nxt    = tgt_halt_region;
						if (!tgt_halt_region) busy_nxt = 1'b1;
					end
				end
			end
			S_RUN: begin
				if (op_done) begin
					state_nxt  = S_IDLE;
					halt_nxt   = 1'b0;
					enable_nxt = 1'b0;
				end
			end
			default: state_nxt = S_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r   <= S_IDLE;
			enable_r  <= CTRL_RESET[CTRL_ENABLE_BIT];
			busy_r    <= 1'b0;
			halt_r    <= 1'b0;
			refused_r <= 1'b0;
			ignored_r <= 1'b0;
			erase_r   <= 1'b0;
			write_r   <= 1'b0;
			page_r    <= '0;
		end else begin
			state_r   <= state_nxt;
			enable_r  <= enable_nxt;
			busy_r    <= busy_nxt;
			halt_r    <= halt_nxt;
			refused_r <= refused_nxt;
			ignored_r <= ignored_nxt;
			erase_r   <= erase_nxt;
			write_r   <= write_nxt;
			page_r    <= page_nxt;
		end
	end

	prog_timer #(.CYCLES(PROG_CYC)) u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (start_pulse),
		.done    (op_done)
	);

	assign prdata          = rdata_r;
	assign pready          = ready_r;
	assign pslverr         = err_r;
	assign cpu_halt        = halt_r;
	assign rw_region_block = busy_r;
	assign flash_erase     = erase_r;
	assign flash_write     = write_r;
	assign flash_page      = page_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_ignore_app;
		@(posedge pclk) disable iff (!presetn)
		store_program_memory_op && enable_r && state_r == S_IDLE && !from_loader
		|=> !flash_erase && !flash_write && ignored_r;
	endproperty
	a_ignore_app: assert property (p_ignore_app) else $error("op from application ran");
	property p_loader_start;
		@(posedge pclk) disable iff (!presetn)
		store_program_memory_op && enable_r && state_r == S_IDLE && from_loader && !locked
		|=> (flash_erase || flash_write) && flash_page == $past(tgt_page);
	endproperty
	a_loader_start: assert property (p_loader_start) else $error("loader op not started");
	property p_boundary;
		@(posedge pclk) disable iff (!presetn)
		loader_size_fuses == 2'h3 |-> boundary == 10'h3fc;
	endproperty
	a_boundary: assert property (p_boundary) else $error("boundary ignores fuses");
	property p_lock;
		@(posedge pclk) disable iff (!presetn)
		store_program_memory_op && enable_r && state_r == S_IDLE && from_loader
		&& spm_req.kind == OP_WRITE && locked |=> !flash_write && refused_r;
	endproperty
	a_lock: assert property (p_lock) else $error("locked write accepted");
	property p_halt_whole;
		@(posedge pclk) disable iff (!presetn)
		halt_r && !op_done |=> halt_r && state_r == S_RUN;
	endproperty
	a_halt_whole: assert property (p_halt_whole) else $error("halt dropped early");
	property p_no_halt_rw;
		@(posedge pclk) disable iff (!presetn)
		(flash_erase || flash_write) && flash_page < HALT_REGION_FIRST_PAGE
		|-> !cpu_halt && rw_region_block;
	endproperty
	a_no_halt_rw: assert property (p_no_halt_rw) else $error("fetch halted for rw page");
	property p_loader_in_halt;
		@(posedge pclk) disable iff (!presetn)
		boundary >= HALT_REGION_FIRST_PAGE;
	endproperty
	a_loader_in_halt: assert property (p_loader_in_halt) else $error("loader outside halt region");
	property p_busy_hold;
		@(posedge pclk) disable iff (!presetn)
		busy_r && !(wr_ctrl && pwdata[CTRL_RWCLEAR_BIT] && state_r == S_IDLE) |=> busy_r;
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy flag fell by itself");
	property p_busy_while_run;
		@(posedge pclk) disable iff (!presetn)
		state_r == S_RUN && !halt_r |-> busy_r ##1 (busy_r || state_r == S_IDLE);
	endproperty
	a_busy_while_run: assert property (p_busy_while_run) else $error("busy low while blocked");
endmodule

// ==== common/flash_sp_pkg.sv ====
/*
 Shared constants and types of the Flash self-programming controller.
 Assumes a word-addressed program Flash split into fixed-size pages.
*/
package flash_sp_pkg;
	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int WADDR_W      = 17;
	localparam int PAGE_W       = 10;
	localparam int PAGE_WORDS_W = WADDR_W - PAGE_W;
	// First page of the halt-during-write region; the top 4096 words
	localparam logic [PAGE_W-1:0] HALT_REGION_FIRST_PAGE = 10'h3e0;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ      = 100;
	localparam int PROG_TIME_US = 4;
	localparam int PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;

	// ------------------------------------------------------------
	// Register byte offsets and fields
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CONFIG = 8'h08;
	localparam int CTRL_ENABLE_BIT   = 0;
	localparam int CTRL_RWCLEAR_BIT  = 1;
	localparam int ST_BUSY_BIT       = 0;
	localparam int ST_ACTIVE_BIT     = 1;
	localparam int ST_HALT_BIT       = 2;
	localparam int ST_REFUSED_BIT    = 3;
	localparam int ST_IGNORED_BIT    = 4;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// ------------------------------------------------------------
	// Lock modes (two bits each, 1 = unprogrammed)
	// ------------------------------------------------------------
	localparam logic [1:0] LOCK_MODE1 = 2'h3;
	localparam logic [1:0] LOCK_MODE2 = 2'h2;
	localparam logic [1:0] LOCK_MODE3 = 2'h0;

	typedef enum logic {OP_ERASE, OP_WRITE} op_kind_type;

	typedef struct packed {
		op_kind_type         kind;
		logic [WADDR_W-1:0]  target;
		logic [WADDR_W-1:0]  pc;
	} spm_req_type;
endpackage

// ==== hw/prog_timer.sv ====
/*
 Counts the duration of one page erase or page write.
 Assumes start is a one-cycle pulse and is not repeated while busy.
*/
`timescale 1ns/100ps
module prog_timer #(
	parameter int CYCLES = 400
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic start,
	output logic      done
);
	localparam int CW = $clog2(CYCLES + 1);
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic          done_nxt;

	always_comb begin
		cnt_nxt  = cnt_r;
		done_nxt = 1'b0;
		if (start) begin
			cnt_nxt = CW'(CYCLES);
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - CW'(1);
			done_nxt = (cnt_r == CW'(1));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
			done  <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			done  <= done_nxt;
		end
	end
endmodule

// ==== testbench/cpu_loader_model.sv ====
/*
 Behavioural CPU core running loader code that issues store ops.
 Assumes the bench calls issue_op from one process only.
*/
`timescale 1ns/100ps
module cpu_loader_model (
	input  wire logic                  pclk,
	input  wire logic                  cpu_halt,
	input  wire logic                  rw_region_block,
	output logic                       store_program_memory_op,
	output flash_sp_pkg::spm_req_type  spm_req
);
	import flash_sp_pkg::*;

	initial begin
		store_program_memory_op = 1'b0;
		spm_req = '0;
	end

	task automatic issue_op(input op_kind_type k, input logic [16:0] t, input logic [16:0] pc);
		// A halted core executes nothing, so it cannot issue either
		while (cpu_halt === 1'b1) @(posedge pclk);
		// Code in the blocked region is never fetched until software clears busy
		if (rw_region_block === 1'b1 && pc[16:7] < HALT_REGION_FIRST_PAGE) return;
		@(posedge pclk);
		store_program_memory_op <= 1'b1;
		spm_req <= '{kind: k, target: t, pc: pc};
		@(posedge pclk);
		store_program_memory_op <= 1'b0;
		// Released request lines do not keep the last value
		spm_req <= spm_req_type'(~spm_req);
	endtask
endmodule

// ==== testbench/flash_self_program_tb_top.sv ====
/*
 Self-checking bench of the Flash self-programming controller.
 Assumes the design answers APB with its own pready and a short op count.
*/
`timescale 1ns/100ps
module flash_self_program_tb_top;
	import flash_sp_pkg::*;
	localparam int N = 8;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slv_err;
	logic        store_program_memory_op, cpu_halt, rw_region_block, flash_erase, flash_write;
	logic [1:0]  loader_size_fuses, app_lock_bits, loader_lock_bits;
	logic [7:0]  paddr;
	logic [9:0]  flash_page;
	logic [31:0] pwdata, prdata, rd;
	spm_req_type spm_req;
	int          mismatches, total_checks, n;

	flash_self_program #(.PROG_CYC(N)) i_flash_self_program (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.store_program_memory_op(store_program_memory_op), .spm_req(spm_req),
		.loader_size_fuses(loader_size_fuses), .app_lock_bits(app_lock_bits),
		.loader_lock_bits(loader_lock_bits), .cpu_halt(cpu_halt),
		.rw_region_block(rw_region_block), .flash_erase(flash_erase),
		.flash_write(flash_write), .flash_page(flash_page));
	cpu_loader_model i_cpu_loader_model (.pclk(pclk), .cpu_halt(cpu_halt),
		.rw_region_block(rw_region_block), .store_program_memory_op(store_program_memory_op),
		.spm_req(spm_req));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int w;
		w = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			w++;
		end while (pready !== 1'b1 && w < 20);
		if (w >= 20) mismatches++;
		rd = prdata;
		slv_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rst(input logic [1:0] f, input logic [1:0] al, input logic [1:0] ll);
		@(posedge pclk);
		presetn <= 1'b0;
		loader_size_fuses <= f;
		app_lock_bits <= al;
		loader_lock_bits <= ll;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFS_CONFIG, 32'h0);
		chk(rd, {26'h0, ll, al, f});
	endtask

	task automatic do_op(input op_kind_type k, input logic [16:0] t, input logic [16:0] pc);
		apb(1'b1, OFS_CTRL, 32'h1);
		i_cpu_loader_model.issue_op(k, t, pc);
		#1;
	endtask

	task automatic wait_idle;
		n = 0;
		do begin
			apb(1'b0, OFS_STATUS, 32'h0);
			n++;
		end while (rd[ST_ACTIVE_BIT] !== 1'b0 && n < 20);
		if (rd[ST_ACTIVE_BIT] !== 1'b0) mismatches++;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs;
		apb(1'b0, OFS_CTRL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h0c, 32'h0);
		chk(slv_err, 1'b1);
		chk(rd, 32'h0);
		apb(1'b1, OFS_STATUS, 32'h1f);
		chk(slv_err, 1'b1);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h0);
	endtask

	task automatic t_app_ignored;
		do_op(OP_WRITE, 17'h00800, 17'h00100);
		chk({flash_write, flash_erase}, 2'b00);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h10);
		apb(1'b1, OFS_CTRL, 32'h1000);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h0);
	endtask

	task automatic t_rww_write;
		do_op(OP_WRITE, 17'h00800, 17'h1fe00);
		chk({flash_write, flash_erase, cpu_halt, rw_region_block}, 4'b1001);
		chk(flash_page, 10'h010);
		// Clearing busy while the op runs must not unblock the region
		apb(1'b1, OFS_CTRL, 32'h2);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h3);
		wait_idle();
		chk(rd, 32'h1);
		chk(rw_region_block, 1'b1);
		apb(1'b1, OFS_CTRL, 32'h2);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk({rd[0], rw_region_block}, 2'b00);
	endtask

	task automatic t_halt_erase;
		rst(2'b00, LOCK_MODE1, LOCK_MODE1);
		do_op(OP_ERASE, 17'h1f000, 17'h1f000);
		chk({flash_erase, cpu_halt, rw_region_block, flash_page}, {3'b110, 10'h3e0});
		n = 0;
		while (cpu_halt === 1'b1 && n < 50) begin
			@(posedge pclk);
			#1;
			n++;
		end
		chk(n >= N && n <= N + 1, 1'b1);
		wait_idle();
		chk(rd, 32'h0);
	endtask

	task automatic t_fuses;
		rst(2'b11, LOCK_MODE1, LOCK_MODE1);
		do_op(OP_WRITE, 17'h00800, 17'h1f800);
		chk(flash_write, 1'b0);
		rst(2'b01, LOCK_MODE1, LOCK_MODE1);
		do_op(OP_WRITE, 17'h00800, 17'h1f800);
		chk(flash_write, 1'b1);
		wait_idle();
	endtask

	task automatic t_locks;
		rst(2'b11, LOCK_MODE2, LOCK_MODE1);
		do_op(OP_WRITE, 17'h00800, 17'h1fe00);
		chk(flash_write, 1'b0);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h8);
		do_op(OP_ERASE, 17'h00800, 17'h1fe00);
		chk(flash_erase, 1'b1);
		wait_idle();
		apb(1'b1, OFS_CTRL, 32'h2);
		do_op(OP_WRITE, 17'h1fe80, 17'h1fe00);
		chk({flash_write, cpu_halt, flash_page}, {2'b11, 10'h3fd});
		wait_idle();
		rst(2'b11, LOCK_MODE1, LOCK_MODE3);
		do_op(OP_WRITE, 17'h1fe80, 17'h1fe00);
		chk(flash_write, 1'b0);
	endtask

	// ----------------------------------------
	// Sequence and verdict
	// ----------------------------------------
	task automatic conclude;
		$display("Checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		loader_size_fuses = 2'b11;
		app_lock_bits = LOCK_MODE1;
		loader_lock_bits = LOCK_MODE1;
		mismatches = 0;
		total_checks = 0;
		rst(2'b11, LOCK_MODE1, LOCK_MODE1);
		t_regs();
		t_app_ignored();
		t_rww_write();
		t_halt_erase();
		t_fuses();
		t_locks();
		conclude();
	end

	// Whole run needs a few hundred cycles; far beyond that means a hang
	initial begin
		#200000;
		mismatches++;
		conclude();
	end
endmodule
